//--- hw/crips_seq.sv
// Reset, power-up initialisation and mirror park sequencer.
// Assumes external PLL lock and flash loader with start/done handshakes.
`include "crips_defines.svh"
`default_nettype none
package crips_pkg;
	typedef enum logic [2:0]
	{
		CRIPS_PLL = 3'b000,
		CRIPS_LOAD = 3'b001,
		CRIPS_RUN = 3'b010,
		CRIPS_NPARK = 3'b011,
		CRIPS_FPARK = 3'b100,
		CRIPS_PARKED = 3'b101
	} crips_state_e;
endpackage

module crips_seq
	import crips_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_fast_park_req_n,
	input wire logic i_projection_enable_req,
	input wire logic i_pll_locked,
	input wire logic i_load_done,
	input wire logic i_flash_serial_clk,
	input wire logic i_flash_serial_out,
	input wire logic i_flash_select0_n,
	input wire logic i_flash_select1_n,
	input wire logic [`CRIPS_GPIO_W-1:0] i_gpio_out,
	input wire logic [`CRIPS_GPIO_W-1:0] i_gpio_dir_out,
	input wire logic i_light_select_0,
	input wire logic i_light_select_1,
	output logic o_load_start,
	output logic o_host_irq,
	output logic o_flash_serial_clk,
	output logic o_flash_serial_clk_oe_n,
	output logic o_flash_serial_out,
	output logic o_flash_serial_out_oe_n,
	output logic o_flash_select0_n,
	output logic o_flash_select0_n_oe_n,
	output logic o_flash_select1_n,
	output logic o_flash_select1_n_oe_n,
	output logic [`CRIPS_GPIO_W-1:0] o_gpio,
	output logic [`CRIPS_GPIO_W-1:0] o_gpio_oe_n,
	output logic o_light_select_0,
	output logic o_light_select_1,
	output logic o_mirror_array_reset_n,
	output logic o_parking,
	output logic o_parked
);
	import crips_pkg::*;

	logic run_sync;
	logic park_n_sync;
	logic proj_sync;
	crips_state_e state;
	crips_state_e next_state;
	logic [`CRIPS_CNT_W-1:0] cnt;
	logic [`CRIPS_CNT_W-1:0] next_cnt;
	logic pll_q;
	logic pll_s;
	logic done_q;
	logic done_s;

	// Release is synchronised; assertion still acts at once.
	crips_sync u_rel (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_async(1'b1),
		.o_sync(run_sync));
	crips_sync u_park (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_async(i_fast_park_req_n), .o_sync(park_n_sync));
	crips_sync u_proj (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_async(i_projection_enable_req), .o_sync(proj_sync));

	// PLL lock and loader done come from other clocking; sync them too
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pll_q <= 1'b0;
			pll_s <= 1'b0;
			done_q <= 1'b0;
			done_s <= 1'b0;
		end
		else
		begin
			pll_q <= i_pll_locked;
			pll_s <= pll_q;
			done_q <= i_load_done;
			done_s <= done_q;
		end
	end

	wire cnt_zero = (cnt == '0);
	wire in_run = (state == CRIPS_RUN);
	wire fast_req = run_sync && !park_n_sync && (state != CRIPS_FPARK)
		&& (state != CRIPS_PARKED);
	// Uses the next state so irq fall and mirror release share one edge
	wire init_busy = (next_state == CRIPS_PLL) || (next_state == CRIPS_LOAD);

	always_comb
	begin
		next_state = state;
		next_cnt = cnt_zero ? cnt : cnt - `CRIPS_CNT_W'(1);
		if (fast_req)
		begin
			next_state = CRIPS_FPARK;
			next_cnt = `CRIPS_CNT_W'(`CRIPS_FAST_PARK_CYC);
		end
		else if (run_sync)
		begin
			case (state)
				CRIPS_PLL:
				begin
					if (pll_s)
						next_state = CRIPS_LOAD;
				end
				CRIPS_LOAD:
				begin
					if (done_s)
						next_state = CRIPS_RUN;
				end
				CRIPS_RUN:
				begin
					if (!proj_sync)
					begin
						next_state = CRIPS_NPARK;
						next_cnt = `CRIPS_CNT_W'(`CRIPS_NORMAL_PARK_CYC - 1);
					end
				end
				CRIPS_NPARK, CRIPS_FPARK:
				begin
					if (cnt_zero)
						next_state = CRIPS_PARKED;
				end
				CRIPS_PARKED:
				begin
					if (proj_sync && park_n_sync)
						next_state = CRIPS_RUN;
				end
				default:
					next_state = CRIPS_PLL;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= CRIPS_PLL;
			cnt <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// Pins float or sit low in reset; become active after release
	wire act = run_sync;
	wire drive_mirror = act && (next_state == CRIPS_RUN);

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_host_irq <= 1'b0;
			o_load_start <= 1'b0;
			o_flash_serial_clk <= 1'b0;
			o_flash_serial_clk_oe_n <= 1'b1;
			o_flash_serial_out <= 1'b0;
			o_flash_serial_out_oe_n <= 1'b1;
			o_flash_select0_n <= 1'b1;
			o_flash_select0_n_oe_n <= 1'b1;
			o_flash_select1_n <= 1'b1;
			o_flash_select1_n_oe_n <= 1'b1;
			o_gpio <= '0;
			o_gpio_oe_n <= '1;
			o_light_select_0 <= 1'b0;
			o_light_select_1 <= 1'b0;
			o_mirror_array_reset_n <= 1'b0;
			o_parking <= 1'b0;
			o_parked <= 1'b0;
		end
		else
		begin
			o_host_irq <= act && init_busy;
			o_load_start <= act && (next_state == CRIPS_LOAD);
			o_flash_serial_clk <= i_flash_serial_clk;
			o_flash_serial_clk_oe_n <= !act;
			o_flash_serial_out <= i_flash_serial_out;
			o_flash_serial_out_oe_n <= !act;
			o_flash_select0_n <= i_flash_select0_n;
			o_flash_select0_n_oe_n <= !act;
			o_flash_select1_n <= i_flash_select1_n;
			o_flash_select1_n_oe_n <= !act;
			o_gpio <= i_gpio_out;
			o_gpio_oe_n <= act ? ~i_gpio_dir_out : '1;
			// Light off while parking protects the mirrors
			o_light_select_0 <= drive_mirror && i_light_select_0;
			o_light_select_1 <= drive_mirror && i_light_select_1;
			o_mirror_array_reset_n <= act && !init_busy && (next_state != CRIPS_PARKED);
			o_parking <= (next_state == CRIPS_NPARK) || (next_state == CRIPS_FPARK);
			o_parked <= (next_state == CRIPS_PARKED);
		end
	end
endmodule
`default_nettype wire

//--- hw/crips_defines.svh
// Constants for the reset, init and park sequencer.
// Assumes a 50 MHz system clock.
`ifndef CRIPS_DEFINES_SVH
`define CRIPS_DEFINES_SVH
`define CRIPS_CLK_HZ 50000000
`define CRIPS_FAST_PARK_US 32
`define CRIPS_FAST_PARK_CYC ((`CRIPS_FAST_PARK_US * 50) - 1)
`define CRIPS_NORMAL_PARK_MS 20
`define CRIPS_NORMAL_PARK_CYC (`CRIPS_NORMAL_PARK_MS * 50000)
`define CRIPS_PLL_LOCK_CYC 256
`define CRIPS_GPIO_W 20
`define CRIPS_CNT_W 20
`endif

//--- hw/crips_sync.sv
// Two-flop synchroniser for a pin level.
// Input may be asynchronous to i_sys_clk.
`default_nettype none
module crips_sync
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_async,
	output logic o_sync
);
	logic meta;
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta <= 1'b0;
			o_sync <= 1'b0;
		end
		else
		begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule
`default_nettype wire

//--- tb/crips_partner.sv
// Model of the PLL and flash loader beside the sequencer.
// Assumes the sequencer's clock and reset.
`default_nettype none
module crips_partner
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_load_start,
	output logic o_pll_locked,
	output logic o_load_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt <= 4'h0;
			o_pll_locked <= 1'h0;
			o_load_done <= 1'h0;
		end
		else
		begin
			cnt <= cnt + 4'h1;
			// Lock after a pause, load answers only once started
			if (cnt == 4'h9)
				o_pll_locked <= 1'h1;
			o_load_done <= o_load_done | i_load_start;
		end
	end
endmodule
`default_nettype wire

//--- tb/crips_seq_sva.sv
// Checker for the sequencer's port behaviour.
// Bound to every crips_seq instance.
`default_nettype none
module crips_seq_sva
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_fast_park_req_n,
	input wire logic i_projection_enable_req,
	input wire logic i_pll_locked,
	input wire logic i_load_done,
	input wire logic o_load_start,
	input wire logic o_host_irq,
	input wire logic o_light_select_0,
	input wire logic o_light_select_1,
	input wire logic o_mirror_array_reset_n,
	input wire logic o_parking,
	input wire logic o_parked
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	wire lit = o_light_select_0 | o_light_select_1;
	irq_busy_a: assert property ($rose(o_host_irq) |-> !o_load_start && !o_mirror_array_reset_n) else $error("irq rose badly");
	load_order_a: assert property ($rose(o_load_start) |-> $past(i_pll_locked, 2)) else $error("load before lock");
	init_done_a: assert property ($fell(o_host_irq) |-> $past(i_load_done, 2) && o_mirror_array_reset_n) else $error("bad init done");
	park_dark_a: assert property (o_parking |-> !lit) else $error("lights on in park");
	fast_park_a: assert property ($fell(i_fast_park_req_n) && !o_parked |-> ##[1:4] (o_parking || o_parked)) else $error("no fast park");
	park_cause_a: assert property ($rose(o_parking) |-> $past(!i_fast_park_req_n || !i_projection_enable_req, 2)) else $error("park without cause");
	parked_off_a: assert property (o_parked |-> !o_mirror_array_reset_n && !lit) else $error("parked outputs live");
	lights_run_a: assert property (lit |-> !o_host_irq && o_mirror_array_reset_n && !o_parking) else $error("lights outside run");
	cover property ($fell(o_host_irq));
	cover property ($rose(o_parking));
	cover property ($rose(o_parked));
endmodule
bind crips_seq crips_seq_sva u_crips_seq_sva (
	.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n),
	.i_fast_park_req_n(i_fast_park_req_n),
	.i_projection_enable_req(i_projection_enable_req),
	.i_pll_locked(i_pll_locked),
	.i_load_done(i_load_done),
	.o_load_start(o_load_start),
	.o_host_irq(o_host_irq),
	.o_light_select_0(o_light_select_0),
	.o_light_select_1(o_light_select_1),
	.o_mirror_array_reset_n(o_mirror_array_reset_n),
	.o_parking(o_parking),
	.o_parked(o_parked)
);
`default_nettype wire

//--- tb/testbench.sv
// Bench for the sequencer: reset, init, normal and fast park.
// Assumes the partner model answers lock and load.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, fp_n = 1, proj = 1, lock, done, ls, irq, park, pkd, mr_n, l0, l1;
	logic [19:0] core = 20'hA5C3E, gp, oe;
	logic [3:0] fo, foe;
	int bad_count = 0, tests_run = 0, cyc = 0, i;
	always #10 clk = ~clk;
	always @(posedge clk)
		if (++cyc == 20000)
		begin
			bad_count++;
			results();
		end
	crips_partner u_crips_partner (.i_sys_clk(clk), .i_rst_n(rst_n), .i_load_start(ls),
		.o_pll_locked(lock), .o_load_done(done));
	crips_seq u_crips_seq (.i_sys_clk(clk), .i_rst_n(rst_n), .i_fast_park_req_n(fp_n),
		.i_projection_enable_req(proj), .i_pll_locked(lock), .i_load_done(done),
		.i_flash_serial_clk(core[2]), .i_flash_serial_out(core[3]), .i_flash_select0_n(core[4]),
		.i_flash_select1_n(core[5]), .i_gpio_out(core), .i_gpio_dir_out(~core),
		.i_light_select_0(core[0]), .i_light_select_1(core[1]), .o_load_start(ls),
		.o_host_irq(irq), .o_flash_serial_clk(fo[0]), .o_flash_serial_clk_oe_n(foe[0]),
		.o_flash_serial_out(fo[1]), .o_flash_serial_out_oe_n(foe[1]),
		.o_flash_select0_n(fo[2]), .o_flash_select0_n_oe_n(foe[2]), .o_flash_select1_n(fo[3]),
		.o_flash_select1_n_oe_n(foe[3]), .o_gpio(gp), .o_gpio_oe_n(oe),
		.o_light_select_0(l0), .o_light_select_1(l1), .o_mirror_array_reset_n(mr_n),
		.o_parking(park), .o_parked(pkd));
	task chk(input string n, input logic [19:0] e, input logic [19:0] s);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task results();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task t_reset();
		@(negedge clk) rst_n = 0;
		@(negedge clk);
		chk("gpio oe", 20'hFFFFF, oe);
		chk("flash oe", 20'hF, {16'h0, foe});
		chk("reset lows", 20'h0, {l0, l1, mr_n, irq, park, pkd});
		@(negedge clk) rst_n = 1;
		$display("reset test done");
	endtask
	task t_init();
		for (i = 0; i < 5 && irq !== 1; i++) @(negedge clk);
		chk("irq busy", 20'h1, irq);
		chk("mirror init", 20'h0, mr_n);
		// Host holds off I2C until this fall
		for (i = 0; i < 60 && irq !== 0; i++) @(negedge clk);
		chk("irq done", 20'h0, irq);
		chk("mirror run", 20'h1, mr_n);
		chk("load idle", 20'h0, ls);
		// Flip the core pattern so every pin bit is seen both ways
		core = ~core;
		@(negedge clk);
		chk("gpio", core, gp);
		chk("gpio oe", core, oe);
		chk("flash", {16'h0, core[5:2]}, {16'h0, fo});
		chk("lights", {18'h0, core[0], core[1]}, {18'h0, l0, l1});
		$display("init test done");
	endtask
	task t_park();
		@(negedge clk) proj = 0;
		for (i = 0; i < 10 && park !== 1; i++) @(negedge clk);
		chk("parking", 20'h1, park);
		chk("lights off", 20'h0, {l0, l1});
		repeat (1700) @(negedge clk);
		chk("still parking", 20'h0, pkd);
		fp_n = 0;
		repeat (1500) @(negedge clk);
		chk("fast early", 20'h0, pkd);
		for (i = 0; i < 200 && pkd !== 1; i++) @(negedge clk);
		chk("fast parked", 20'h1, pkd);
		chk("mirror parked", 20'h0, mr_n);
		fp_n = 1;
		proj = 1;
		$display("park test done");
	endtask
	initial
	begin
		t_reset();
		t_init();
		t_park();
		t_reset();
		t_init();
		results();
	end
endmodule
`default_nettype wire
